//--- core/acpcr_regs.sv
// Power and clock control register bank of the audio codec, Wishbone slave.
`timescale 1ns/1ns
module acpcr_regs (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Microphone bias.
  output logic             bias_generator_en,
  output logic             bias_current_detect_en,
  output logic      [2:0]  bias_voltage_code,
  output logic      [2:0]  bias_voltage_level,
  // Digital microphone.
  output logic             digital_mic_oversample_sel,
  output logic             digital_mic_config_error,
  output logic             left_mic_processing_en,
  output logic             right_mic_processing_en,
  // Analogue path power.
  output logic             left_input_amp_en,
  output logic             right_input_amp_en,
  output logic             left_headphone_en,
  output logic             right_headphone_en,
  output logic             left_line_out_en,
  output logic             right_line_out_en,
  output logic             left_converter_en,
  output logic             right_converter_en,
  // Clock controls.
  output logic             timeout_clk_div_sixteen,
  output logic             timeout_clk_times_four,
  output logic             master_clk_half,
  output logic             system_clock_source_sel,
  // Derived clock enables.
  output logic             system_clock_tick,
  output logic             zero_cross_timeout_clock_tick
);

  typedef struct packed {
    logic [acpcr_pkg::NUM_REGS-1:0][15:0] regs;
    logic                                 ack;
    logic [15:0]                          rdata;
  } acpcr_state_t;

  acpcr_state_t s;
  acpcr_state_t next_s;
  logic [1:0]   rst_sync;
  logic         rst_core_n;
  logic [5:0]   word_index;
  logic [15:0]  lane_mask;
  logic         bus_request;
  logic [10:0]  system_clock_period;
  logic [10:0]  timeout_period;

  // Reset is asserted at once and released through two flip-flops, so the
  // bank never leaves reset on an edge that races the external deassertion.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_core_n = rst_sync[1];

  // Bus decode: word index from the byte address, byte lanes from sel.
  assign word_index  = wb_adr_i[7:2];
  assign bus_request = wb_cyc_i & wb_stb_i;
  assign lane_mask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Next state: the read word is captured as ack rises, and a write lands
  // only on the edge where the master sees ack high. An unmapped address
  // is still acknowledged, reads zero and drops the write, so a stray
  // access cannot hang the bus.
  always_comb begin
    next_s     = s;
    next_s.ack = bus_request & ~s.ack;
    if (bus_request && !s.ack) begin
      next_s.rdata = 16'h0000;
      for (int i = 0; i < acpcr_pkg::NUM_REGS; i++) begin
        if (word_index == acpcr_pkg::REG_INDEX[i]) begin
          next_s.rdata = s.regs[i] & acpcr_pkg::REG_MASK[i];
        end
      end
    end
    if (bus_request && s.ack && wb_we_i) begin
      for (int i = 0; i < acpcr_pkg::NUM_REGS; i++) begin
        if (word_index == acpcr_pkg::REG_INDEX[i]) begin
          next_s.regs[i] = ((s.regs[i] & ~lane_mask) |
                            (wb_dat_i[15:0] & lane_mask)) &
                           acpcr_pkg::REG_MASK[i];
        end
      end
    end
  end

  // State register; the reset copy of every register is a constant table.
  always_ff @(posedge ref_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      s.regs  <= acpcr_pkg::REG_RESET;
      s.ack   <= 1'b0;
      s.rdata <= 16'h0000;
    end else begin
      s <= next_s;
    end
  end

  // Bus outputs; the upper half of the data word is always zero.
  assign wb_ack_o = s.ack;
  assign wb_dat_o = {16'h0000, s.rdata};

  // Microphone bias controls.
  assign bias_current_detect_en =
    s.regs[acpcr_pkg::SLOT_MIC_BIAS_CONTROL][acpcr_pkg::BIT_DETECT_EN];
  assign bias_generator_en =
    s.regs[acpcr_pkg::SLOT_MIC_BIAS_CONTROL][acpcr_pkg::BIT_BIAS_EN];
  assign bias_voltage_code =
    s.regs[acpcr_pkg::SLOT_MIC_BIAS_VOLTAGE_SELECT]
          [acpcr_pkg::VCODE_MSB:acpcr_pkg::VCODE_LSB];

  // The analogue bias ladder has only five steps, so the three reserved
  // codes above the top step all fold onto it.
  assign bias_voltage_level = (bias_voltage_code >= acpcr_pkg::VCODE_TOP) ?
                              acpcr_pkg::VCODE_TOP :
                              bias_voltage_code;

  // Digital microphone controls.
  assign digital_mic_oversample_sel =
    s.regs[acpcr_pkg::SLOT_DIGITAL_MIC_OVERSAMPLING]
          [acpcr_pkg::BIT_OVERSAMPLE];
  assign left_mic_processing_en =
    s.regs[acpcr_pkg::SLOT_CONVERTER_POWER][acpcr_pkg::BIT_LEFT_MIC];
  assign right_mic_processing_en =
    s.regs[acpcr_pkg::SLOT_CONVERTER_POWER][acpcr_pkg::BIT_RIGHT_MIC];

  // Flags a microphone channel running on the reserved oversampling
  // setting; the bank does not correct it, software must clear the bit.
  assign digital_mic_config_error =
    digital_mic_oversample_sel &
    (left_mic_processing_en | right_mic_processing_en);

  // Input amplifier power.
  assign left_input_amp_en =
    s.regs[acpcr_pkg::SLOT_INPUT_AMP_POWER][acpcr_pkg::BIT_LEFT];
  assign right_input_amp_en =
    s.regs[acpcr_pkg::SLOT_INPUT_AMP_POWER][acpcr_pkg::BIT_RIGHT];

  // Headphone output power.
  assign left_headphone_en =
    s.regs[acpcr_pkg::SLOT_HEADPHONE_POWER][acpcr_pkg::BIT_LEFT];
  assign right_headphone_en =
    s.regs[acpcr_pkg::SLOT_HEADPHONE_POWER][acpcr_pkg::BIT_RIGHT];

  // Line output power.
  assign left_line_out_en =
    s.regs[acpcr_pkg::SLOT_LINE_OUTPUT_POWER][acpcr_pkg::BIT_LEFT];
  assign right_line_out_en =
    s.regs[acpcr_pkg::SLOT_LINE_OUTPUT_POWER][acpcr_pkg::BIT_RIGHT];

  // Converter power.
  assign left_converter_en =
    s.regs[acpcr_pkg::SLOT_CONVERTER_POWER][acpcr_pkg::BIT_LEFT_DAC];
  assign right_converter_en =
    s.regs[acpcr_pkg::SLOT_CONVERTER_POWER][acpcr_pkg::BIT_RIGHT_DAC];

  // Clock scaling and source controls.
  assign timeout_clk_div_sixteen =
    s.regs[acpcr_pkg::SLOT_CLOCK_SCALING_CONTROL]
          [acpcr_pkg::BIT_DIV_SIXTEEN];
  assign timeout_clk_times_four =
    s.regs[acpcr_pkg::SLOT_CLOCK_SCALING_CONTROL]
          [acpcr_pkg::BIT_TIMES_FOUR];
  assign master_clk_half =
    s.regs[acpcr_pkg::SLOT_CLOCK_SCALING_CONTROL]
          [acpcr_pkg::BIT_MCLK_HALF];
  assign system_clock_source_sel =
    s.regs[acpcr_pkg::SLOT_SYSTEM_CLOCK_SOURCE]
          [acpcr_pkg::BIT_CLOCK_SOURCE];

  // System clock enable: every cycle, or every second cycle when halved.
  assign system_clock_period = master_clk_half ? acpcr_pkg::SYSTEM_CLOCK_PERIOD_HALF :
                                           acpcr_pkg::SYSTEM_CLOCK_PERIOD_FULL;

  // Timeout period: sixteen times longer when divided, four times shorter
  // when multiplied, both at once giving four times the base period. The
  // base is a multiple of four so the shortened period stays exact.
  always_comb begin
    unique case ({timeout_clk_div_sixteen, timeout_clk_times_four})
      2'b00: timeout_period = acpcr_pkg::ZERO_CROSS_TIMEOUT_CLOCK_BASE_PERIOD;
      2'b01: timeout_period = acpcr_pkg::ZERO_CROSS_TIMEOUT_CLOCK_BASE_PERIOD >> 2;
      2'b10: timeout_period = 11'(acpcr_pkg::ZERO_CROSS_TIMEOUT_CLOCK_BASE_PERIOD << 4);
      2'b11: timeout_period = 11'(acpcr_pkg::ZERO_CROSS_TIMEOUT_CLOCK_BASE_PERIOD << 2);
    endcase
  end

  // Divider producing the system clock enable.
  acpcr_tick_divider u_system_clock_div (
    .clk        (ref_clk),
    .rst_core_n (rst_core_n),
    .period     (system_clock_period),
    .tick       (system_clock_tick)
  );

  // Divider producing the zero-cross timeout clock enable.
  acpcr_tick_divider u_timeout_div (
    .clk        (ref_clk),
    .rst_core_n (rst_core_n),
    .period     (timeout_period),
    .tick       (zero_cross_timeout_clock_tick)
  );

endmodule

//--- core/acpcr_pkg.sv
// Constants for the power and clock control register bank of the audio codec.
package acpcr_pkg;

  // Register slots held by the bank, in storage order.
  localparam int NUM_REGS = 9;
  localparam int SLOT_MIC_BIAS_CONTROL          = 0;
  localparam int SLOT_MIC_BIAS_VOLTAGE_SELECT   = 1;
  localparam int SLOT_DIGITAL_MIC_OVERSAMPLING  = 2;
  localparam int SLOT_INPUT_AMP_POWER           = 3;
  localparam int SLOT_HEADPHONE_POWER           = 4;
  localparam int SLOT_LINE_OUTPUT_POWER         = 5;
  localparam int SLOT_CONVERTER_POWER           = 6;
  localparam int SLOT_CLOCK_SCALING_CONTROL     = 7;
  localparam int SLOT_SYSTEM_CLOCK_SOURCE       = 8;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_MIC_BIAS_CONTROL         = 6'h06;
  localparam logic [5:0] IDX_MIC_BIAS_VOLTAGE_SELECT  = 6'h07;
  localparam logic [5:0] IDX_DIGITAL_MIC_OVERSAMPLING = 6'h0A;
  localparam logic [5:0] IDX_INPUT_AMP_POWER          = 6'h0C;
  localparam logic [5:0] IDX_HEADPHONE_POWER          = 6'h0E;
  localparam logic [5:0] IDX_LINE_OUTPUT_POWER        = 6'h0F;
  localparam logic [5:0] IDX_CONVERTER_POWER          = 6'h12;
  localparam logic [5:0] IDX_CLOCK_SCALING_CONTROL    = 6'h14;
  localparam logic [5:0] IDX_SYSTEM_CLOCK_SOURCE      = 6'h16;

  // Index table, element zero last in the concatenation.
  localparam logic [NUM_REGS-1:0][5:0] REG_INDEX = {
    IDX_SYSTEM_CLOCK_SOURCE, IDX_CLOCK_SCALING_CONTROL, IDX_CONVERTER_POWER,
    IDX_LINE_OUTPUT_POWER, IDX_HEADPHONE_POWER, IDX_INPUT_AMP_POWER,
    IDX_DIGITAL_MIC_OVERSAMPLING, IDX_MIC_BIAS_VOLTAGE_SELECT,
    IDX_MIC_BIAS_CONTROL};

  // Implemented bits of each register; all other bits read as zero.
  localparam logic [NUM_REGS-1:0][15:0] REG_MASK = {
    16'h4000, 16'h6001, 16'h000F, 16'h0003, 16'h0003, 16'h0003,
    16'h0001, 16'h0007, 16'h0003};

  // Reset value of each register.
  localparam logic [NUM_REGS-1:0][15:0] REG_RESET = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0001, 16'h0000, 16'h0000};

  // Field positions.
  localparam int BIT_DETECT_EN     = 1;
  localparam int BIT_BIAS_EN       = 0;
  localparam int VCODE_LSB         = 0;
  localparam int VCODE_MSB         = 2;
  localparam int BIT_OVERSAMPLE    = 0;
  localparam int BIT_LEFT          = 1;
  localparam int BIT_RIGHT         = 0;
  localparam int BIT_LEFT_DAC      = 3;
  localparam int BIT_RIGHT_DAC     = 2;
  localparam int BIT_LEFT_MIC      = 1;
  localparam int BIT_RIGHT_MIC     = 0;
  localparam int BIT_DIV_SIXTEEN   = 14;
  localparam int BIT_TIMES_FOUR    = 13;
  localparam int BIT_MCLK_HALF     = 0;
  localparam int BIT_CLOCK_SOURCE  = 14;

  // Bias level codes: every code at or above the top one means the top level.
  localparam logic [2:0] VCODE_TOP = 3'h4;

  // Tick periods in reference clock cycles.
  localparam logic [10:0] SYSTEM_CLOCK_PERIOD_FULL = 11'h001;
  localparam logic [10:0] SYSTEM_CLOCK_PERIOD_HALF = 11'h002;
  localparam logic [10:0] ZERO_CROSS_TIMEOUT_CLOCK_BASE_PERIOD  = 11'h040;

endpackage

//--- core/acpcr_tick_divider.sv
// Programmable divider that emits a one-cycle enable pulse every period.
`timescale 1ns/1ns
module acpcr_tick_divider (
  // Clock and synchronised reset.
  input  wire logic        clk,
  input  wire logic        rst_core_n,
  // Period in clock cycles, at least one.
  input  wire logic [10:0] period,
  // One-cycle enable pulse.
  output logic             tick
);

  typedef struct packed {
    logic [10:0] count;
    logic        tick;
  } acpcr_div_state_t;

  acpcr_div_state_t s;
  acpcr_div_state_t next_s;

  // The wrap test uses greater-or-equal so that a period shortened by
  // software while the count is high wraps at once instead of overrunning.
  always_comb begin
    next_s = s;
    if (s.count >= 11'(period - 11'h001)) begin
      next_s.count = 11'h000;
      next_s.tick  = 1'b1;
    end else begin
      next_s.count = 11'(s.count + 11'h001);
      next_s.tick  = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule

//--- testbench/acpcr_regs_chk.sv
// Assertion checker for the power and clock control register bank.
`timescale 1ns/1ns
module acpcr_regs_chk (
  // Clock, reset and bus answer.
  input wire logic        ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Watched controls and derived ticks.
  input wire logic [2:0]  bias_voltage_code, bias_voltage_level,
  input wire logic        digital_mic_oversample_sel, digital_mic_config_error,
  input wire logic        left_mic_processing_en, right_mic_processing_en,
  input wire logic        left_converter_en, right_converter_en,
  input wire logic        timeout_clk_div_sixteen, timeout_clk_times_four,
  input wire logic        master_clk_half, system_clock_tick,
  input wire logic        zero_cross_timeout_clock_tick
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [10:0] gap;
  logic        seen, steady;
  // Cycles since the last timeout tick; a scaling change voids the interval,
  // because the new period only settles after the following wrap.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap    <= 11'h000;
      seen   <= 1'b0;
      steady <= 1'b0;
    end else begin
      gap    <= zero_cross_timeout_clock_tick ? 11'h001 : gap + 11'h001;
      seen   <= seen | zero_cross_timeout_clock_tick;
      steady <= $changed({timeout_clk_div_sixteen, timeout_clk_times_four})
                ? 1'b0 : (steady | zero_cross_timeout_clock_tick);
    end
  end
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
  property p_dat_high;
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000;
  endproperty
  a_dat_high: assert property (p_dat_high) else $error("upper data");
  property p_level;
    bias_voltage_level == (bias_voltage_code > 3'h3 ? 3'h4 : bias_voltage_code);
  endproperty
  a_level: assert property (p_level) else $error("bias level");
  property p_cfg_err;
    digital_mic_config_error == (digital_mic_oversample_sel &&
      (left_mic_processing_en || right_mic_processing_en));
  endproperty
  a_cfg_err: assert property (p_cfg_err) else $error("config flag");
  property p_conv_chg;
    $changed({left_converter_en, right_converter_en}) |->
      $past(wb_ack_o) && $past(wb_we_i);
  endproperty
  a_conv_chg: assert property (p_conv_chg) else $error("enable moved");
  property p_sys_half;
    master_clk_half && system_clock_tick |=> !system_clock_tick;
  endproperty
  a_sys_half: assert property (p_sys_half) else $error("half rate");
  property p_sys_full;
    !master_clk_half && system_clock_tick ##1 !master_clk_half
      |-> system_clock_tick;
  endproperty
  a_sys_full: assert property (p_sys_full) else $error("full rate");
  property p_to_gap;
    zero_cross_timeout_clock_tick && seen && steady &&
      $stable({timeout_clk_div_sixteen, timeout_clk_times_four}) |->
      gap == (timeout_clk_div_sixteen ?
        (timeout_clk_times_four ? 11'h100 : 11'h400) :
        (timeout_clk_times_four ? 11'h010 : 11'h040));
  endproperty
  a_to_gap: assert property (p_to_gap) else $error("timeout period");
endmodule
bind acpcr_regs acpcr_regs_chk u_chk (.*);

//--- testbench/acpcr_regs_tb.sv
// Self-checking bench for the power and clock control register bank.
`timescale 1ns/1ns
module acpcr_regs_tb;
  // Ports of the bank, named as the block names them.
  logic        ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        bias_generator_en, bias_current_detect_en;
  logic [2:0]  bias_voltage_code, bias_voltage_level;
  logic        digital_mic_oversample_sel, digital_mic_config_error;
  logic        left_mic_processing_en, right_mic_processing_en;
  logic        left_input_amp_en, right_input_amp_en, left_headphone_en;
  logic        right_headphone_en, left_line_out_en, right_line_out_en;
  logic        left_converter_en, right_converter_en, master_clk_half;
  logic        timeout_clk_div_sixteen, timeout_clk_times_four;
  logic        system_clock_source_sel, system_clock_tick;
  logic        zero_cross_timeout_clock_tick;
  int          fail_count, total_checks;
  // Byte address, writable bits and reset value of each word.
  logic [7:0]  adr_t [9] = '{8'h18, 8'h1C, 8'h28, 8'h30, 8'h38, 8'h3C,
                             8'h48, 8'h50, 8'h58};
  logic [15:0] msk_t [9] = '{16'h0003, 16'h0007, 16'h0001, 16'h0003,
                 16'h0003, 16'h0003, 16'h000F, 16'h6001, 16'h4000};
  logic [15:0] rst_t [9] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000,
                 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  acpcr_regs DUT (.*);
  // Free-running 250 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic check(input string nm, input logic [15:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One classic cycle; the answer is taken only at the edge that shows ack.
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    check("ack", 16'h0001, {15'h0, wb_ack_o});
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Rebuilds a register word from the enable ports that it drives.
  function automatic logic [15:0] img(int i);
    case (i)
      0: return {14'h0, bias_current_detect_en, bias_generator_en};
      1: return {13'h0, bias_voltage_code};
      2: return {15'h0, digital_mic_oversample_sel};
      3: return {14'h0, left_input_amp_en, right_input_amp_en};
      4: return {14'h0, left_headphone_en, right_headphone_en};
      5: return {14'h0, left_line_out_en, right_line_out_en};
      6: return {12'h0, left_converter_en, right_converter_en,
                 left_mic_processing_en, right_mic_processing_en};
      7: return {1'b0, timeout_clk_div_sixteen, timeout_clk_times_four,
                 12'h0, master_clk_half};
      default: return {1'b0, system_clock_source_sel, 14'h0};
    endcase
  endfunction
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, adr_t[i], 4'hF, 32'h0);
      check("reset read", rst_t[i], rd[15:0]);
      check("reset port", rst_t[i], img(i));
    end
    $display("reset test done");
  endtask
  // Alternating patterns catch swapped left and right bits.
  task automatic t_bits;
    logic [15:0] p [3] = '{16'hAAAA, 16'h5555, 16'hFFFF};
    for (int i = 0; i < 9; i++)
      for (int j = 0; j < 3; j++) begin
        wb(1'b1, adr_t[i], 4'hF, {16'hFFFF, p[j]});
        @(posedge ref_clk);
        check("port", p[j] & msk_t[i], img(i));
        wb(1'b0, adr_t[i], 4'hF, 32'h0);
        check("read", p[j] & msk_t[i], rd[15:0]);
      end
    wb(1'b1, 8'h50, 4'hF, 32'h0);
    wb(1'b1, 8'h50, 4'h2, 32'hFFFF);
    wb(1'b0, 8'h50, 4'hF, 32'h0);
    check("upper lane", 16'h6000, rd[15:0]);
    wb(1'b1, 8'h20, 4'hF, 32'hFFFF);
    wb(1'b0, 8'h20, 4'hF, 32'h0);
    check("unmapped", 16'h0000, rd[15:0]);
    $display("bit test done");
  endtask
  task automatic t_level;
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, 8'h1C, 4'hF, c);
      @(posedge ref_clk);
      check("level", c > 3 ? 16'h4 : 16'(c), {13'h0, bias_voltage_level});
    end
    $display("level test done");
  endtask
  task automatic t_err;
    wb(1'b1, 8'h48, 4'hF, 32'h3);
    wb(1'b1, 8'h28, 4'hF, 32'h1);
    @(posedge ref_clk);
    check("cfg flag", 16'h1, {15'h0, digital_mic_config_error});
    wb(1'b1, 8'h28, 4'hF, 32'h0);
    @(posedge ref_clk);
    check("cfg flag", 16'h0, {15'h0, digital_mic_config_error});
    $display("config test done");
  endtask
  // Third tick gap is measured, after any period change has settled.
  task automatic t_ticks;
    int n;
    int per [4] = '{64, 16, 1024, 256};
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, 8'h50, 4'hF, {17'h0, k[1:0], 13'h0});
      for (int t = 0; t < 3; t++) begin
        n = 0;
        do begin
          @(posedge ref_clk);
          n++;
        end while (zero_cross_timeout_clock_tick !== 1'b1 && n < 1100);
      end
      check("tick gap", 16'(per[k]), 16'(n));
    end
    for (int h = 1; h >= 0; h--) begin
      wb(1'b1, 8'h50, 4'hF, h);
      repeat (4) @(posedge ref_clk);
      n = 0;
      repeat (8) begin
        @(posedge ref_clk);
        if (system_clock_tick === 1'b1) n++;
      end
      check("sys ticks", h ? 16'h4 : 16'h8, 16'(n));
    end
    $display("tick test done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence; the second reset lands on non-default contents.
  initial begin
    rst_n    = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    do_reset();
    t_reset();
    t_bits();
    do_reset();
    t_reset();
    t_level();
    t_err();
    t_ticks();
    finish_test();
  end
  // Watchdog well beyond the longest tick measurement.
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
endmodule
